// file: dpe_pkg.sv
package dpe_pkg;
	// data-space addresses
	localparam logic [7:0]  WIN_LO          = 8'h40;
	localparam logic [7:0]  WIN_HI          = 8'h7F;
	localparam logic [7:0]  BANK_HI         = 8'h3F;
	localparam logic [7:0]  ADDR_WIN_BASE   = 8'hC9;
	localparam logic [7:0]  ADDR_BANK       = 8'hE8;
	localparam logic [7:0]  ADDR_CTL        = 8'hEA;
	// bank select bit positions
	localparam int          BANK_NVM0       = 0;
	localparam int          BANK_NVM1       = 1;
	localparam int          BANK_RAM2       = 4;
	// control register bit positions
	localparam int          CTL_STANDBY     = 6;
	localparam int          CTL_START       = 3;
	localparam int          CTL_MODE        = 2;
	localparam int          CTL_BUSY        = 1;
	localparam int          CTL_ENABLE      = 0;
	localparam logic [7:0]  CTL_RESET       = 8'h00;
	// fixed answers
	localparam logic [7:0]  WO_READ         = 8'hFF;
	localparam logic [7:0]  DEAD_READ       = 8'hFF;
	// page codes of the bank memory
	localparam logic [1:0]  PAGE_NVM0       = 2'h0;
	localparam logic [1:0]  PAGE_NVM1       = 2'h1;
	localparam logic [1:0]  PAGE_RAM2       = 2'h2;
	localparam logic [1:0]  PAGE_NONE       = 2'h3;
	localparam int          ROW_BYTES       = 8;
	// programming cycle length in core clocks
	localparam logic [23:0] PROG_CYCLES_DEF = 24'h0007D0;

	typedef enum logic [2:0] {
		DPE_IDLE     = 3'b001,
		DPE_BYTE     = 3'b010,
		DPE_ROW      = 3'b100
	} dpe_fsm_t;
endpackage

// file: dpe_mem.sv
`timescale 1ns/1ns
module dpe_mem (
	// clock
	input  wire logic       clk,
	// access port
	input  wire logic       we,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);
	logic [7:0] mem [0:255];

	// registered read, old data on a write to the same word
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// file: dpe_paging.sv
`timescale 1ns/1ns
module dpe_paging
	import dpe_pkg::*;
#(
	parameter logic [23:0] PROG_CYCLES = dpe_pkg::PROG_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET,
	// core data-space access
	input  wire logic [7:0]  ADDR,
	input  wire logic        WR,
	input  wire logic        RD,
	input  wire logic [7:0]  WDATA,
	output logic      [7:0]  RDATA,
	output logic             RDATA_HIT,
	// program memory read port
	output logic      [11:0] PROM_ADDR,
	input  wire logic [7:0]  PROM_DATA,
	// status
	output logic             PROG_BUSY
);
	import dpe_pkg::*;

	typedef struct packed {
		dpe_fsm_t        fsm;
		logic [5:0]      window_base;
		logic [7:0]      bank;
		logic            standby;
		logic            enable;
		logic            mode;
		logic            start;
		logic            busy;
		logic            row_valid;
		logic [1:0]      row_page;
		logic [2:0]      row_addr;
		logic [7:0][7:0] row_data;
		logic [7:0]      row_mask;
		logic [23:0]     cnt;
		logic [3:0]      wr_idx;
		logic            rd_valid;
		logic            rd_mem;
		logic [7:0]      rd_hold;
	} dpe_state_t;

	dpe_state_t st;
	dpe_state_t next_st;
	logic       mem_we;
	logic [7:0] mem_addr;
	logic [7:0] mem_wd;
	logic [7:0] mem_q;
	logic [1:0] page;
	logic       nvm_page;
	logic       nvm_ok;
	logic       in_bank;
	logic       in_win;
	logic       ram_use;

	function automatic logic [1:0] page_of(input logic [7:0] b);
		if (b[BANK_NVM0]) begin
			page_of = PAGE_NVM0;
		end else if (b[BANK_NVM1]) begin
			page_of = PAGE_NVM1;
		end else if (b[BANK_RAM2]) begin
			page_of = PAGE_RAM2;
		end else begin
			page_of = PAGE_NONE;
		end
	endfunction

	function automatic logic [7:0] ctl_image(input dpe_state_t s);
		ctl_image = CTL_RESET;
		ctl_image[CTL_BUSY] = s.busy;
	endfunction

	assign page      = page_of(st.bank);
	assign nvm_page  = (page == PAGE_NVM0) || (page == PAGE_NVM1);
	assign nvm_ok    = !st.standby && !st.busy;
	assign in_bank   = ADDR <= BANK_HI;
	assign in_win    = (ADDR >= WIN_LO) && (ADDR <= WIN_HI);
	assign ram_use   = in_bank && (page == PAGE_RAM2) && (RD || WR);
	assign PROM_ADDR = {st.window_base, ADDR[5:0]};
	assign PROG_BUSY = st.busy;
	assign RDATA     = st.rd_mem ? mem_q : st.rd_hold;
	assign RDATA_HIT = st.rd_valid;

	always_comb begin
		next_st = st;
		mem_we = 1'b0;
		mem_addr = {page, ADDR[5:0]};
		mem_wd = WDATA;
		next_st.rd_valid = 1'b0;
		next_st.rd_mem = 1'b0;
		// core reads, answered one cycle later
		if (RD) begin
			next_st.rd_valid = 1'b1;
			next_st.rd_hold = DEAD_READ;
			if (in_win) begin
				next_st.rd_hold = PROM_DATA;
			end else if (in_bank && page != PAGE_NONE) begin
				if (page == PAGE_RAM2) begin
					next_st.rd_mem = 1'b1;
				end else if (nvm_ok && !st.mode) begin
					next_st.rd_mem = 1'b1;
				end
			end else if (ADDR == ADDR_WIN_BASE || ADDR == ADDR_BANK) begin
				next_st.rd_hold = WO_READ;
			end else if (ADDR == ADDR_CTL) begin
				next_st.rd_hold = ctl_image(st);
			end else begin
				next_st.rd_valid = 1'b0;
			end
		end
		// core writes
		if (WR) begin
			if (ADDR == ADDR_WIN_BASE) begin
				next_st.window_base = WDATA[5:0];
			end else if (ADDR == ADDR_BANK) begin
				next_st.bank = WDATA;
			end else if (ADDR == ADDR_CTL && !st.busy) begin
				next_st.standby = WDATA[CTL_STANDBY];
				next_st.enable = WDATA[CTL_ENABLE];
				next_st.mode = WDATA[CTL_MODE];
				if (!WDATA[CTL_MODE] || !st.mode) begin
					next_st.row_valid = 1'b0;
					next_st.row_mask = 8'h00;
				end
				if (WDATA[CTL_START] && WDATA[CTL_ENABLE]
						&& WDATA[CTL_MODE] && st.mode) begin
					next_st.start = 1'b1;
					next_st.busy = 1'b1;
					next_st.fsm = DPE_ROW;
					next_st.cnt = 24'h000000;
					next_st.wr_idx = 4'h0;
				end
			end else if (in_bank && page == PAGE_RAM2) begin
				mem_we = 1'b1;
			end else if (in_bank && nvm_page && nvm_ok && st.enable) begin
				if (st.mode) begin
					if (!st.row_valid || (ADDR[5:3] == st.row_addr
							&& page == st.row_page)) begin
						next_st.row_valid = 1'b1;
						next_st.row_page = page;
						next_st.row_addr = ADDR[5:3];
						next_st.row_data[ADDR[2:0]] = WDATA;
						next_st.row_mask[ADDR[2:0]] = 1'b1;
					end
				end else begin
					mem_we = 1'b1;
					next_st.busy = 1'b1;
					next_st.fsm = DPE_BYTE;
					next_st.cnt = 24'h000000;
				end
			end
		end
		// programming cycles
		unique case (st.fsm)
			DPE_IDLE: begin
			end
			DPE_BYTE: begin
				next_st.cnt = st.cnt + 24'h000001;
				if (st.cnt == PROG_CYCLES - 24'h000001) begin
					next_st.busy = 1'b0;
					next_st.fsm = DPE_IDLE;
				end
			end
			DPE_ROW: begin
				// a core RAM page access owns the port; the row byte waits
				if (st.wr_idx < 4'(ROW_BYTES) && !ram_use) begin
					mem_addr = {st.row_page, st.row_addr,
						st.wr_idx[2:0]};
					mem_wd = st.row_data[st.wr_idx[2:0]];
					mem_we = st.row_mask[st.wr_idx[2:0]];
					next_st.wr_idx = st.wr_idx + 4'h1;
				end
				next_st.cnt = st.cnt + 24'h000001;
				if (st.cnt == PROG_CYCLES - 24'h000001) begin
					next_st.busy = 1'b0;
					next_st.mode = 1'b0;
					next_st.start = 1'b0;
					next_st.row_valid = 1'b0;
					next_st.row_mask = 8'h00;
					next_st.fsm = DPE_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			st <= '0;
			st.fsm <= DPE_IDLE;
			st.window_base <= st.window_base;
			st.bank <= st.bank;
			st.standby <= CTL_RESET[CTL_STANDBY];
			st.enable <= CTL_RESET[CTL_ENABLE];
			st.mode <= CTL_RESET[CTL_MODE];
			st.start <= CTL_RESET[CTL_START];
			st.busy <= CTL_RESET[CTL_BUSY];
		end else begin
			st <= next_st;
		end
	end

	dpe_mem u_mem (
		.clk   (CLK),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wd),
		.rdata (mem_q)
	);

	// helper: length of each busy period
	logic [23:0] busy_len;

	always_ff @(posedge CLK) begin
		if (RESET || !st.busy) begin
			busy_len <= 24'h000000;
		end else begin
			busy_len <= busy_len + 24'h000001;
		end
	end

	a_win_addr_map: assert property (@(posedge CLK) disable iff (RESET)
		WR && ADDR == ADDR_WIN_BASE |=> PROM_ADDR[11:6] == $past(WDATA[5:0]))
		else $error("window address not formed from base and offset");

	a_win_read_data: assert property (@(posedge CLK) disable iff (RESET)
		RD && in_win |=> RDATA_HIT && RDATA == $past(PROM_DATA))
		else $error("window read did not return program memory byte");

	a_wo_read_fixed: assert property (@(posedge CLK) disable iff (RESET)
		RD && (ADDR == ADDR_WIN_BASE || ADDR == ADDR_BANK)
		|=> RDATA_HIT && RDATA == WO_READ)
		else $error("write-only register read gave wrong value");

	a_busy_length: assert property (@(posedge CLK) disable iff (RESET)
		st.busy ##1 !st.busy |-> busy_len == PROG_CYCLES)
		else $error("programming cycle length wrong");

	a_byte_start: assert property (@(posedge CLK) disable iff (RESET)
		WR && in_bank && nvm_page && nvm_ok && st.enable && !st.mode
		|=> st.busy && st.fsm == DPE_BYTE)
		else $error("byte write did not start programming");

	a_no_enable: assert property (@(posedge CLK) disable iff (RESET)
		!st.busy && !st.enable && !(WR && ADDR == ADDR_CTL) |=> !st.busy)
		else $error("programming started without enable");

	a_ctl_locked: assert property (@(posedge CLK) disable iff (RESET)
		st.busy && WR && ADDR == ADDR_CTL
		|=> st.standby == $past(st.standby) && st.enable == $past(st.enable))
		else $error("control write took effect while busy");

	a_start_gated: assert property (@(posedge CLK) disable iff (RESET)
		!st.busy && !st.mode && WR && ADDR == ADDR_CTL |=> !st.start)
		else $error("start set without row mode");

	a_row_end_clear: assert property (@(posedge CLK) disable iff (RESET)
		st.fsm == DPE_ROW && !next_st.busy
		|=> !st.mode && !st.start && st.row_mask == 8'h00)
		else $error("row mode or start not cleared at end of cycle");

	a_row_locked: assert property (@(posedge CLK) disable iff (RESET)
		WR && in_bank && st.mode && st.row_valid && !st.busy
		&& ADDR[5:3] != st.row_addr |=> st.row_mask == $past(st.row_mask))
		else $error("write to another row reached the latches");

	a_busy_read: assert property (@(posedge CLK) disable iff (RESET)
		RD && in_bank && nvm_page && st.busy |=> RDATA == DEAD_READ)
		else $error("nvm read while busy returned cell data");

	a_ctl_after_reset: assert property (@(posedge CLK)
		$past(RESET) && !RESET |-> !st.busy && !st.mode && !st.enable)
		else $error("control register not cleared by reset");

	a_ctl_image: assert property (@(posedge CLK) disable iff (RESET)
		RD && ADDR == ADDR_CTL
		|=> RDATA_HIT && RDATA == {6'h00, $past(st.busy), 1'h0})
		else $error("control read does not show busy alone");

	a_mode_clear: assert property (@(posedge CLK) disable iff (RESET)
		!st.busy && !st.mode && WR && ADDR == ADDR_CTL && WDATA[CTL_MODE]
		|=> st.mode && !st.row_valid && st.row_mask == 8'h00)
		else $error("setting row mode did not clear the latches");

	a_start_row: assert property (@(posedge CLK) disable iff (RESET)
		!st.busy && st.mode && WR && ADDR == ADDR_CTL
		&& WDATA[CTL_START] && WDATA[CTL_ENABLE] && WDATA[CTL_MODE]
		|=> st.busy && st.start && st.fsm == DPE_ROW)
		else $error("row start with enable and mode did not begin");

	a_standby_idle: assert property (@(posedge CLK) disable iff (RESET)
		st.standby && !st.busy && !(WR && ADDR == ADDR_CTL) |=> !st.busy)
		else $error("programming started in standby");

	a_no_bank_hit: assert property (@(posedge CLK) disable iff (RESET)
		RD && in_bank && page == PAGE_NONE |=> !RDATA_HIT)
		else $error("bank area served with no bank selected");

	a_byte_cell: assert property (@(posedge CLK) disable iff (RESET)
		WR && in_bank && nvm_page && nvm_ok && st.enable && !st.mode
		|-> mem_we && mem_addr == {page, ADDR[5:0]} && mem_wd == WDATA)
		else $error("byte write did not reach its own cell");

	a_ram_write: assert property (@(posedge CLK) disable iff (RESET)
		WR && in_bank && page == PAGE_RAM2
		|-> mem_we && mem_addr == {PAGE_RAM2, ADDR[5:0]})
		else $error("RAM page write lost");

	a_busy_bound: assert property (@(posedge CLK) disable iff (RESET)
		st.busy |-> busy_len < PROG_CYCLES)
		else $error("busy held past the programming cycle");

	a_row_no_read: assert property (@(posedge CLK) disable iff (RESET)
		RD && in_bank && nvm_page && st.mode
		|=> RDATA_HIT && RDATA == DEAD_READ)
		else $error("nvm read in row mode returned cell data");
endmodule

// file: dpe_prom_model.sv
`timescale 1ns/1ns
module dpe_prom_model (
	// program memory read port
	input  wire logic [11:0] addr,
	output logic      [7:0]  data
);
	// contents are a fixed pattern of the address: addr[7:0] XOR {addr[11:8], 4'h3}
	assign data = addr[7:0] ^ {addr[11:8], 4'h3};
endmodule

// file: dpe_paging_tb.sv
`timescale 1ns/1ns
module dpe_paging_tb;
	import dpe_pkg::*;
	localparam logic [23:0] CYC = 24'h000010;
	logic        CLK;
	logic        RESET;
	logic        WR;
	logic        RD;
	logic        RDATA_HIT;
	logic        PROG_BUSY;
	logic [7:0]  ADDR;
	logic [7:0]  WDATA;
	logic [7:0]  RDATA;
	logic [7:0]  PROM_DATA;
	logic [11:0] PROM_ADDR;
	int          err_total;
	int          checked;

	dpe_paging #(.PROG_CYCLES(CYC)) dut_u (.CLK(CLK), .RESET(RESET),
		.ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA), .RDATA(RDATA),
		.RDATA_HIT(RDATA_HIT), .PROM_ADDR(PROM_ADDR),
		.PROM_DATA(PROM_DATA), .PROG_BUSY(PROG_BUSY));
	dpe_prom_model prom_u (.addr(PROM_ADDR), .data(PROM_DATA));

	initial CLK = 1'h0;
	always #25 CLK = ~CLK;

	function automatic logic [7:0] prom_byte(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], 4'h3};
	endfunction

	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		ADDR = a;
		WDATA = d;
		WR = 1'h1;
		@(negedge CLK);
		WR = 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic hit,
		input logic [7:0] exp, input string what);
		@(negedge CLK);
		ADDR = a;
		RD = 1'h1;
		@(negedge CLK);
		RD = 1'h0;
		chk({what, " hit"}, {7'h00, RDATA_HIT}, {7'h00, hit});
		if (hit)
			chk(what, RDATA, exp);
	endtask

	task automatic busy_is(input logic b, input string what);
		@(negedge CLK);
		chk(what, {7'h00, PROG_BUSY}, {7'h00, b});
	endtask

	// bounded wait for the end of a programming cycle
	task automatic idle_wait;
		int n;
		n = 0;
		while (PROG_BUSY !== 1'h0 && n < 100) begin
			@(negedge CLK);
			n++;
		end
		if (n >= 100)
			chk("idle", 8'h01, 8'h00);
	endtask

	task automatic bwrite(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		busy_is(1'h1, "prefill busy");
		idle_wait();
	endtask

	task automatic done(input string t);
		$display("test %s done", t);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#(50 * 5000);
		err_total++;
		wrap_up();
	end

	initial begin
		err_total = 0;
		checked = 0;
		RESET = 1'h1;
		WR = 1'h0;
		RD = 1'h0;
		ADDR = 8'h00;
		WDATA = 8'h00;
		repeat (6) @(posedge CLK);
		@(negedge CLK);
		RESET = 1'h0;
		rd(ADDR_CTL, 1'h1, 8'h00, "ctl reset");
		rd(8'h80, 1'h0, 8'h00, "unmapped");
		done("reset");
		wr(ADDR_WIN_BASE, 8'hC5);
		rd(8'h40, 1'h1, prom_byte(12'h140), "win low");
		rd(8'h7F, 1'h1, prom_byte(12'h17F), "win high");
		wr(ADDR_WIN_BASE, 8'h3F);
		rd(8'h6A, 1'h1, prom_byte(12'hFEA), "win top");
		rd(ADDR_WIN_BASE, 1'h1, WO_READ, "base read");
		done("window");
		wr(ADDR_BANK, 8'h10);
		wr(8'h3F, 8'h3F);
		wr(ADDR_WIN_BASE, 8'h3F);
		rd(8'h3F, 1'h1, 8'h3F, "base image");
		wr(8'h05, 8'hA5);
		rd(8'h05, 1'h1, 8'hA5, "ram page");
		rd(ADDR_BANK, 1'h1, WO_READ, "bank read");
		@(negedge CLK);
		RESET = 1'h1;
		repeat (2) @(negedge CLK);
		RESET = 1'h0;
		rd(8'h05, 1'h1, 8'hA5, "bank kept");
		rd(8'h6A, 1'h1, prom_byte(12'hFEA), "base kept");
		wr(ADDR_BANK, 8'h00);
		rd(8'h05, 1'h0, 8'h00, "no bank");
		done("bank");
		wr(ADDR_CTL, 8'h01);
		wr(ADDR_BANK, 8'h01);
		wr(8'h10, 8'h5A);
		busy_is(1'h1, "byte busy");
		rd(ADDR_CTL, 1'h1, 8'h02, "ctl busy");
		rd(8'h10, 1'h1, DEAD_READ, "read busy");
		wr(ADDR_CTL, 8'h00);
		idle_wait();
		wr(8'h11, 8'h66);
		busy_is(1'h1, "enable kept");
		idle_wait();
		rd(8'h10, 1'h1, 8'h5A, "byte 10");
		rd(8'h11, 1'h1, 8'h66, "byte 11");
		wr(ADDR_CTL, 8'h00);
		wr(8'h10, 8'h77);
		busy_is(1'h0, "no enable");
		rd(8'h10, 1'h1, 8'h5A, "no enable keep");
		wr(ADDR_CTL, 8'h41);
		rd(8'h10, 1'h1, DEAD_READ, "standby read");
		wr(8'h10, 8'h12);
		busy_is(1'h0, "standby write");
		done("byte");
		wr(ADDR_CTL, 8'h01);
		bwrite(8'h18, 8'h11);
		bwrite(8'h1A, 8'h22);
		bwrite(8'h20, 8'h33);
		wr(ADDR_CTL, 8'h09);
		busy_is(1'h0, "start no mode");
		wr(ADDR_CTL, 8'h05);
		wr(8'h18, 8'hAA);
		wr(8'h1B, 8'hBB);
		wr(8'h20, 8'hCC);
		rd(8'h18, 1'h1, DEAD_READ, "row mode read");
		wr(ADDR_CTL, 8'h0D);
		busy_is(1'h1, "row busy");
		idle_wait();
		rd(ADDR_CTL, 1'h1, 8'h00, "row end ctl");
		rd(8'h18, 1'h1, 8'hAA, "row 18");
		rd(8'h1A, 1'h1, 8'h22, "row 1A");
		rd(8'h1B, 1'h1, 8'hBB, "row 1B");
		rd(8'h20, 1'h1, 8'h33, "other row");
		wr(ADDR_CTL, 8'h09);
		busy_is(1'h0, "mode cleared");
		done("row");
		wrap_up();
	end
endmodule
